// ---- pkg/dsf_pkg.sv ----
// Package of constants for the disk controller status-flag block.
package dsf_pkg;
  // ****************************************************************
  // Register byte offsets
  // ****************************************************************
  localparam logic [7:0] OFS_FLAGS = 8'h00;
  localparam logic [7:0] OFS_CMD = 8'h04;
  localparam logic [7:0] OFS_CTRL = 8'h08;
  localparam logic [7:0] OFS_MASK = 8'h0c;
  // ****************************************************************
  // Field positions in the interface flag register
  // ****************************************************************
  localparam int FLG_ACT_TO = 2;
  localparam int FLG_UPD_TO = 3;
  localparam int FLG_ADDR_ERR = 4;
  localparam int FLG_RD_ERR = 5;
  localparam int FLG_SECT_ERR = 6;
  localparam int FLG_NOT_BUSY = 7;
  // ****************************************************************
  // Command word fields and control bits
  // ****************************************************************
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_OP_W = 4;
  localparam int CMD_TRK_LSB = 8;
  localparam int CMD_TRK_W = 9;
  localparam int CTRL_DEV_CLEAR = 0;
  localparam int CTRL_SYS_INIT = 1;
  localparam int MASK_IRQ_BIT = 5;
  localparam logic [CMD_TRK_W-1:0] TRACK_MAX = 9'h197;
  localparam logic [7:0] MASK_RESET = 8'h00;
  localparam logic [7:0] FLAGS_RESET = 8'h80;
  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam longint CLK_HZ = 100000000;
  localparam longint UPD_TIMEOUT_MS = 2000;
  localparam longint ACT_TIMEOUT_MS = 16000;
  localparam int TMR_W = 32;
  localparam logic [TMR_W-1:0] UPD_TICKS = TMR_W'(UPD_TIMEOUT_MS * (CLK_HZ / 1000));
  localparam logic [TMR_W-1:0] ACT_TICKS = TMR_W'(ACT_TIMEOUT_MS * (CLK_HZ / 1000));
  // ****************************************************************
  // Operation codes
  // ****************************************************************
  typedef enum logic [3:0] {
    OP_NONE = 4'h0,
    OP_READ = 4'h1,
    OP_CHECK = 4'h2,
    OP_WRITE = 4'h3,
    OP_FORMAT = 4'h4,
    OP_RESTORE = 4'h5,
    OP_UPD_READ = 4'h6,
    OP_UPD_WRITE = 4'h7,
    OP_UPD_CHECK = 4'h8,
    OP_ALL = 4'hf
  } dsf_op_t;
endpackage : dsf_pkg

// ---- rtl/dsf_timer.sv ----
// One-shot timeout counter used for the update and activity timers.
`timescale 1ns/1ps
module dsf_timer #(
  parameter logic [dsf_pkg::TMR_W-1:0] TICKS = dsf_pkg::UPD_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic start,
  input wire logic stop,
  output logic running,
  output logic expired
);
  logic [dsf_pkg::TMR_W-1:0] cnt_r;
  logic run_r;
  logic exp_r;
  wire logic at_end = run_r && (cnt_r == TICKS - 1'b1);

  // Stop wins over start, so an abort cannot leave a stale timer running.
  // Expiry is a one-cycle pulse, so a later clear is never undone by a lingering level.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else if (stop) begin
      cnt_r <= '0;
      run_r <= 1'b0;
      exp_r <= 1'b0;
    end else if (start) begin
      cnt_r <= '0;
      run_r <= 1'b1;
      exp_r <= 1'b0;
    end else if (at_end) begin
      run_r <= 1'b0;
      exp_r <= 1'b1;
    end else begin
      exp_r <= 1'b0;
      if (run_r) begin
        cnt_r <= cnt_r + 1'b1;
      end
    end
  end

  assign running = run_r;
  assign expired = exp_r;
endmodule : dsf_timer

// ---- rtl/dsf_top.sv ----
// Status flags, timers and interrupt of the disk controller behind APB.
`timescale 1ns/1ps
module dsf_top #(
  parameter logic [dsf_pkg::TMR_W-1:0] UPD_TICKS = dsf_pkg::UPD_TICKS,
  parameter logic [dsf_pkg::TMR_W-1:0] ACT_TICKS = dsf_pkg::ACT_TICKS
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic drive_done,
  input wire logic sector_fmt_only,
  output logic drive_start,
  output logic drive_abort,
  output logic [3:0] drive_op,
  output logic [8:0] drive_track,
  output logic irq
);
  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  logic [1:0] sync1_r;
  logic [1:0] sync2_r;
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync1_r <= 2'h0;
      sync2_r <= 2'h0;
    end else begin
      sync1_r <= {sector_fmt_only, drive_done};
      sync2_r <= sync1_r;
    end
  end
  wire logic done_s = sync2_r[0];
  wire logic fmt_only_s = sync2_r[1];

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire logic setup_ph = psel && !penable;
  wire logic wr_acc = psel && penable && pwrite;
  wire logic hit_flags = (paddr == dsf_pkg::OFS_FLAGS);
  wire logic hit_cmd = (paddr == dsf_pkg::OFS_CMD);
  wire logic hit_ctrl = (paddr == dsf_pkg::OFS_CTRL);
  wire logic hit_mask = (paddr == dsf_pkg::OFS_MASK);
  wire logic hit_any = hit_flags || hit_cmd || hit_ctrl || hit_mask;
  wire logic cmd_wr = wr_acc && hit_cmd;
  wire logic ctrl_wr = wr_acc && hit_ctrl;
  wire logic mask_wr = wr_acc && hit_mask;

  // Device clear and system init act alike on this block.
  wire logic clr = ctrl_wr && (pwdata[dsf_pkg::CTRL_DEV_CLEAR] || pwdata[dsf_pkg::CTRL_SYS_INIT]);

  // ****************************************************************
  // State
  // ****************************************************************
  logic busy_r;
  logic lock_r;
  logic [3:0] op_r;
  logic rd_err_r;
  logic addr_err_r;
  logic sect_err_r;
  logic upd_to_r;
  logic act_to_r;
  logic [7:0] mask_r;
  logic irq_r;
  logic start_r;
  logic abort_r;
  logic [8:0] trk_r;
  logic [31:0] prdata_r;
  logic pslverr_r;
  logic pready_r;
  logic upd_run;
  logic upd_exp;
  logic act_run;
  logic act_exp;

  // ****************************************************************
  // Command decode
  // ****************************************************************
  wire logic [3:0] cmd_op = pwdata[dsf_pkg::CMD_OP_LSB +: dsf_pkg::CMD_OP_W];
  wire logic [8:0] cmd_trk = pwdata[dsf_pkg::CMD_TRK_LSB +: dsf_pkg::CMD_TRK_W];
  wire logic op_is_all = (cmd_op == dsf_pkg::OP_ALL);
  wire logic reading = busy_r && (op_r == dsf_pkg::OP_READ);
  // Commands while busy are ignored; only the all-ops word is noticed.
  wire logic cmd_take = cmd_wr && !busy_r && !clr;
  wire logic cmd_locked = cmd_take && lock_r;
  wire logic cmd_run = cmd_take && !lock_r;
  wire logic bad_trk = cmd_trk > dsf_pkg::TRACK_MAX;
  wire logic chk_bad = cmd_run && (cmd_op == dsf_pkg::OP_CHECK) && bad_trk;
  wire logic go = cmd_run && !chk_bad && !op_is_all;
  wire logic act_start = cmd_wr && op_is_all && reading && !clr;
  wire logic fin = busy_r && done_s && !clr;

  wire logic fin_rd_type = (op_r == dsf_pkg::OP_READ) || (op_r == dsf_pkg::OP_CHECK) ||
    (op_r == dsf_pkg::OP_UPD_READ) || (op_r == dsf_pkg::OP_UPD_CHECK);
  wire logic fin_clr_type = (op_r == dsf_pkg::OP_RESTORE) || (op_r == dsf_pkg::OP_FORMAT) ||
    (op_r == dsf_pkg::OP_WRITE) || (op_r == dsf_pkg::OP_UPD_WRITE);
  // A good sector leaves the flag alone, so repeated reads never raise it.
  wire logic rd_err_set = fin && fin_rd_type && fmt_only_s;
  wire logic rd_err_clr = clr || (fin && fin_clr_type);
  wire logic restore_run = cmd_run && (cmd_op == dsf_pkg::OP_RESTORE);
  wire logic upd_start = fin && (op_r == dsf_pkg::OP_UPD_READ);
  wire logic upd_stop = clr || cmd_wr;

  // ****************************************************************
  // Timers
  // ****************************************************************
  dsf_timer #(.TICKS(UPD_TICKS)) u_upd_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(upd_start),
    .stop(upd_stop),
    .running(upd_run),
    .expired(upd_exp)
  );

  dsf_timer #(.TICKS(ACT_TICKS)) u_act_tmr (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .start(act_start),
    .stop(clr),
    .running(act_run),
    .expired(act_exp)
  );

  // ****************************************************************
  // Command sequencing
  // ****************************************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      busy_r <= 1'b0;
      op_r <= 4'h0;
      trk_r <= 9'h000;
      start_r <= 1'b0;
      abort_r <= 1'b0;
    end else begin
      start_r <= go;
      abort_r <= clr && busy_r;
      if (clr) begin
        busy_r <= 1'b0;
      end else if (go) begin
        busy_r <= 1'b1;
        op_r <= cmd_op;
        trk_r <= cmd_trk;
      end else if (done_s) begin
        busy_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Error and timeout flags
  // ****************************************************************
  // Hardware sets win over clears arriving in the same cycle.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rd_err_r <= 1'b0;
      addr_err_r <= 1'b0;
      sect_err_r <= 1'b0;
      upd_to_r <= 1'b0;
      act_to_r <= 1'b0;
      lock_r <= 1'b0;
    end else begin
      if (rd_err_set) begin
        rd_err_r <= 1'b1;
      end else if (rd_err_clr || restore_run) begin
        rd_err_r <= 1'b0;
      end
      if (chk_bad) begin
        addr_err_r <= 1'b1;
        sect_err_r <= 1'b1;
      end else if (clr || restore_run) begin
        addr_err_r <= 1'b0;
        sect_err_r <= 1'b0;
      end
      if (cmd_locked) begin
        upd_to_r <= 1'b1;
      end else if (clr) begin
        upd_to_r <= 1'b0;
      end
      if (upd_exp) begin
        lock_r <= 1'b1;
      end else if (clr) begin
        lock_r <= 1'b0;
      end
      if (act_exp) begin
        act_to_r <= 1'b1;
      end else if (clr) begin
        act_to_r <= 1'b0;
      end
    end
  end

  // ****************************************************************
  // Interrupt
  // ****************************************************************
  wire logic irq_nxt = !busy_r && mask_r[dsf_pkg::MASK_IRQ_BIT];
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      mask_r <= dsf_pkg::MASK_RESET;
      irq_r <= 1'b0;
    end else begin
      if (mask_wr) begin
        mask_r <= pwdata[7:0];
      end
      irq_r <= irq_nxt;
    end
  end

  // ****************************************************************
  // APB read path
  // ****************************************************************
  wire logic [7:0] flags = {!busy_r, sect_err_r, rd_err_r, addr_err_r, upd_to_r, act_to_r,
    2'b00};
  wire logic [31:0] rd_mux = hit_flags ? {24'h000000, flags} :
    hit_mask ? {24'h000000, mask_r} : 32'h00000000;

  // Read data is captured in the setup phase, so every access ends at once.
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      prdata_r <= 32'h00000000;
      pslverr_r <= 1'b0;
      pready_r <= 1'b0;
    end else begin
      pready_r <= 1'b1;
      if (setup_ph) begin
        prdata_r <= rd_mux;
        pslverr_r <= !hit_any;
      end
    end
  end

  assign prdata = prdata_r;
  assign pready = pready_r;
  assign pslverr = pslverr_r;
  assign drive_start = start_r;
  assign drive_abort = abort_r;
  assign drive_op = op_r;
  assign drive_track = trk_r;
  assign irq = irq_r;

  // ****************************************************************
  // Checks
  // ****************************************************************
  property p_bad_check;
    @(posedge clk_sys) disable iff (!rst_n)
      chk_bad |=> addr_err_r && sect_err_r && !start_r;
  endproperty
  a_bad_check: assert property (p_bad_check) else $error("bad-track check missed errors");

  property p_clr_errs;
    @(posedge clk_sys) disable iff (!rst_n)
      (clr && !chk_bad && !rd_err_set) |=> !addr_err_r && !sect_err_r && !rd_err_r;
  endproperty
  a_clr_errs: assert property (p_clr_errs) else $error("clear left an error flag");

  property p_clr_abort;
    @(posedge clk_sys) disable iff (!rst_n)
      (clr && busy_r) |=> !busy_r ##1 irq_r == mask_r[dsf_pkg::MASK_IRQ_BIT];
  endproperty
  a_clr_abort: assert property (p_clr_abort) else $error("clear did not end command");

  property p_good_read;
    @(posedge clk_sys) disable iff (!rst_n)
      (fin && op_r == dsf_pkg::OP_READ && !fmt_only_s && !rd_err_r) |=> !rd_err_r;
  endproperty
  a_good_read: assert property (p_good_read) else $error("good read raised read error");

  property p_lockout;
    @(posedge clk_sys) disable iff (!rst_n)
      (lock_r && cmd_take) |=> upd_to_r && !busy_r && !start_r;
  endproperty
  a_lockout: assert property (p_lockout) else $error("locked command not aborted");

  property p_unlock;
    @(posedge clk_sys) disable iff (!rst_n)
      (clr && !upd_exp) |=> !lock_r && !upd_to_r && !act_to_r && !upd_run && !act_run;
  endproperty
  a_unlock: assert property (p_unlock) else $error("clear kept lockout or timer");

  property p_irq_busy;
    @(posedge clk_sys) disable iff (!rst_n)
      $rose(busy_r) |=> !irq_r;
  endproperty
  a_irq_busy: assert property (p_irq_busy) else $error("interrupt while busy");

  property p_irq_mask;
    @(posedge clk_sys) disable iff (!rst_n)
      (mask_wr && pwdata[7:0] == 8'h20 && !busy_r && !go && !clr) |=> ##1 irq_r;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("no interrupt with mask set");

  property p_irq_zero;
    @(posedge clk_sys) disable iff (!rst_n)
      (mask_wr && pwdata[7:0] == 8'h00) |=> ##1 !irq_r;
  endproperty
  a_irq_zero: assert property (p_irq_zero) else $error("interrupt with zero mask");

  property p_act_start;
    @(posedge clk_sys) disable iff (!rst_n)
      act_start |=> act_run && !act_to_r;
  endproperty
  a_act_start: assert property (p_act_start) else $error("activity timer not started");

  property p_upd_flag;
    @(posedge clk_sys) disable iff (!rst_n)
      upd_exp && !clr |=> lock_r;
  endproperty
  a_upd_flag: assert property (p_upd_flag) else $error("expiry did not lock out");
endmodule : dsf_top

// ---- verif/dsf_drive_model.sv ----
// Behavioural disk drive answering the controller's command pins.
`timescale 1ns/1ps
module dsf_drive_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic drive_start,
  input wire logic drive_abort,
  input wire logic [15:0] delay,
  output logic drive_done
);
  // ****************************************************************
  // Command timing
  // ****************************************************************
  // Done is held for four cycles only, so a stale level can never end the next command early.
  int cnt;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      drive_done <= 1'b0;
    end else if (drive_abort) begin
      cnt <= 0;
      drive_done <= 1'b0;
    end else if (drive_start) begin
      cnt <= int'(delay) + 5;
      drive_done <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      drive_done <= (cnt <= 5) && (cnt > 1);
    end
  end
endmodule : dsf_drive_model

// ---- verif/dsf_top_tb_top.sv ----
// Self-checking testbench of the disk controller status-flag block.
`timescale 1ns/1ps
module dsf_top_tb_top;
  // ****************************************************************
  // Signals
  // ****************************************************************
  localparam logic [31:0] NB = 32'h1 << dsf_pkg::FLG_NOT_BUSY;
  localparam logic [31:0] RE = 32'h1 << dsf_pkg::FLG_RD_ERR;
  localparam logic [31:0] AE = 32'h1 << dsf_pkg::FLG_ADDR_ERR;
  localparam logic [31:0] SE = 32'h1 << dsf_pkg::FLG_SECT_ERR;
  localparam logic [31:0] UT = 32'h1 << dsf_pkg::FLG_UPD_TO;
  localparam logic [31:0] AT = 32'h1 << dsf_pkg::FLG_ACT_TO;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic sector_fmt_only = 1'b0;
  logic [15:0] delay = 16'h0008;
  logic [31:0] prdata;
  logic [31:0] rdat;
  logic pready, pslverr, drive_done, drive_start, drive_abort, irq, last_err;
  logic [3:0] drive_op;
  logic [8:0] drive_track;
  int err_total = 0;
  int total_checks = 0;
  int start_cnt = 0;
  int abort_cnt = 0;
  int cyc = 0;
  int n0;
  dsf_pkg::dsf_op_t set_ops[4] = '{dsf_pkg::OP_READ, dsf_pkg::OP_CHECK, dsf_pkg::OP_UPD_CHECK,
    dsf_pkg::OP_UPD_READ};
  dsf_pkg::dsf_op_t clr_ops[4] = '{dsf_pkg::OP_RESTORE, dsf_pkg::OP_FORMAT, dsf_pkg::OP_WRITE,
    dsf_pkg::OP_UPD_WRITE};
  always #5 clk_sys = ~clk_sys;
  // Short timer counts keep the run brief; the timeout waits below are fixed cycle counts chosen around them.
  dsf_top #(.UPD_TICKS(32'd50), .ACT_TICKS(32'd400)) dut (.clk_sys(clk_sys), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .drive_done(drive_done),
    .sector_fmt_only(sector_fmt_only), .drive_start(drive_start), .drive_abort(drive_abort),
    .drive_op(drive_op), .drive_track(drive_track), .irq(irq));
  dsf_drive_model drv (.clk_sys(clk_sys), .rst_n(rst_n), .drive_start(drive_start),
    .drive_abort(drive_abort), .delay(delay), .drive_done(drive_done));
  // ****************************************************************
  // Tasks
  // ****************************************************************
  task automatic tally_and_finish;
    if (err_total == 0 && total_checks > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : tally_and_finish
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (drive_start === 1'b1) start_cnt <= start_cnt + 1;
    if (drive_abort === 1'b1) abort_cnt <= abort_cnt + 1;
    if (cyc == 20000) begin
      err_total++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) begin
      @(posedge clk_sys);
    end
    rdat = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk_sys);
  endtask : apb
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(rdat, exp);
  endtask : rd
  task automatic cmd(input dsf_pkg::dsf_op_t op, input logic [8:0] trk);
    apb(1'b1, dsf_pkg::OFS_CMD, {15'h0000, trk, 4'h0, op});
  endtask : cmd
  task automatic ctl(input int b);
    apb(1'b1, dsf_pkg::OFS_CTRL, 32'h1 << b);
  endtask : ctl
  task automatic idle;
    apb(1'b0, dsf_pkg::OFS_FLAGS, 32'h0);
    while (rdat[dsf_pkg::FLG_NOT_BUSY] !== 1'b1) begin
      apb(1'b0, dsf_pkg::OFS_FLAGS, 32'h0);
    end
  endtask : idle
  task automatic irq_chk(input logic exp);
    @(negedge clk_sys);
    chk({31'h0, irq}, {31'h0, exp});
    @(posedge clk_sys);
  endtask : irq_chk
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    rd(dsf_pkg::OFS_FLAGS, NB);
    rd(dsf_pkg::OFS_MASK, 32'h0);
    apb(1'b1, dsf_pkg::OFS_FLAGS, 32'hff);
    rd(dsf_pkg::OFS_FLAGS, NB);
    rd(8'h10, 32'h0);
    chk({31'h0, last_err}, 32'h1);
    repeat (10) begin
      cmd(dsf_pkg::OP_READ, 9'h010);
      idle();
      chk(rdat, NB);
    end
    for (int i = 0; i < 4; i++) begin
      sector_fmt_only <= 1'b1;
      cmd(set_ops[i], 9'h020);
      idle();
      chk(rdat, NB | RE);
      cmd(clr_ops[i], 9'h020);
      idle();
      chk(rdat, NB);
    end
    sector_fmt_only <= 1'b0;
    n0 = start_cnt;
    cmd(dsf_pkg::OP_CHECK, 9'h197);
    idle();
    chk(rdat, NB);
    chk(start_cnt - n0, 32'h1);
    chk({23'h0, drive_track}, 32'h197);
    chk({28'h0, drive_op}, {28'h0, dsf_pkg::OP_CHECK});
    for (int b = 0; b < 2; b++) begin
      sector_fmt_only <= 1'b1;
      cmd(dsf_pkg::OP_READ, 9'h030);
      idle();
      sector_fmt_only <= 1'b0;
      n0 = start_cnt;
      cmd(dsf_pkg::OP_CHECK, 9'h198);
      rd(dsf_pkg::OFS_FLAGS, NB | AE | SE | RE);
      chk(start_cnt - n0, 32'h0);
      ctl(b);
      rd(dsf_pkg::OFS_FLAGS, NB);
    end
    cmd(dsf_pkg::OP_CHECK, 9'h1ff);
    rd(dsf_pkg::OFS_FLAGS, NB | AE | SE);
    cmd(dsf_pkg::OP_RESTORE, 9'h000);
    idle();
    chk(rdat, NB);
    cmd(dsf_pkg::OP_UPD_READ, 9'h040);
    idle();
    repeat (30) @(posedge clk_sys);
    cmd(dsf_pkg::OP_UPD_READ, 9'h040);
    idle();
    chk(rdat, NB);
    repeat (70) @(posedge clk_sys);
    n0 = start_cnt;
    cmd(dsf_pkg::OP_READ, 9'h040);
    rd(dsf_pkg::OFS_FLAGS, NB | UT);
    chk(start_cnt - n0, 32'h0);
    ctl(0);
    rd(dsf_pkg::OFS_FLAGS, NB);
    cmd(dsf_pkg::OP_UPD_READ, 9'h040);
    idle();
    chk(start_cnt - n0, 32'h1);
    ctl(1);
    repeat (70) @(posedge clk_sys);
    cmd(dsf_pkg::OP_READ, 9'h040);
    idle();
    chk(rdat, NB);
    delay <= 16'd100;
    cmd(dsf_pkg::OP_READ, 9'h050);
    cmd(dsf_pkg::OP_ALL, 9'h050);
    repeat (340) @(posedge clk_sys);
    rd(dsf_pkg::OFS_FLAGS, NB);
    repeat (100) @(posedge clk_sys);
    rd(dsf_pkg::OFS_FLAGS, NB | AT);
    ctl(0);
    rd(dsf_pkg::OFS_FLAGS, NB);
    apb(1'b1, dsf_pkg::OFS_MASK, 32'h20);
    rd(dsf_pkg::OFS_MASK, 32'h20);
    irq_chk(1'b1);
    delay <= 16'd500;
    for (int b = 0; b < 2; b++) begin
      n0 = abort_cnt;
      cmd(dsf_pkg::OP_READ, 9'h060);
      repeat (2) @(posedge clk_sys);
      irq_chk(1'b0);
      rd(dsf_pkg::OFS_FLAGS, 32'h0);
      ctl(b);
      rd(dsf_pkg::OFS_FLAGS, NB);
      chk(abort_cnt - n0, 32'h1);
      irq_chk(1'b1);
    end
    apb(1'b1, dsf_pkg::OFS_MASK, 32'h0);
    @(posedge clk_sys);
    irq_chk(1'b0);
    tally_and_finish();
  end
endmodule : dsf_top_tb_top
